// ===== src/ios_pkg.sv
/*
  Package for the internal oscillator select and clock output block:
  register offsets, field positions, reset values, modes and timing.
  Assumes a 32-bit AXI4-Lite register bus and a 50 MHz system clock.
*/
package ios_pkg;

  // Register byte offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_TRIM = 4'h4;
  localparam logic [3:0] OFF_CFG = 4'h8;
  localparam logic [3:0] OFF_STAT = 4'hC;

  // Control register fields
  localparam int CTRL_SEL_BIT = 0;
  localparam int CTRL_SLOW_OK_BIT = 1;
  localparam int CTRL_FAST_OK_BIT = 2;
  localparam int CTRL_FSEL_LO = 4;
  localparam logic [2:0] FSEL_RESET = 3'h6;
  localparam logic [2:0] FSEL_SLOW = 3'h0;
  localparam logic [2:0] FSEL_FASTEST = 3'h7;
  localparam logic SEL_RESET = 1'b0;

  // Trim register
  localparam int TRIM_W = 5;
  localparam logic [4:0] TRIM_RESET = 5'h00;
  localparam logic [4:0] TRIM_MAX = 5'h0F;
  localparam logic [4:0] TRIM_MIN = 5'h10;

  // Configuration register fields
  localparam int CFG_MODE_LO = 0;
  localparam int CFG_TSU_BIT = 2;
  localparam int CFG_PWRUP_BIT = 3;
  localparam int CFG_WDOG_BIT = 4;
  localparam int CFG_FCM_BIT = 5;
  localparam logic [5:0] CFG_RESET = 6'h00;

  // Oscillator timing: clock 50 MHz, settle times as counts
  localparam int CLK_MHZ = 50;
  localparam int FAST_SETTLE_US = 2;
  localparam int SLOW_SETTLE_US = 20;
  localparam int FAST_SETTLE_CYC = FAST_SETTLE_US * CLK_MHZ;
  localparam int SLOW_SETTLE_CYC = SLOW_SETTLE_US * CLK_MHZ;
  localparam int DIV_SLOW = 1613;
  localparam int DIV_FAST = 6;

  typedef enum logic [1:0] {
    MODE_RC_DIV,
    MODE_RC_PIN,
    MODE_INT_DIV,
    MODE_INT_PINS
  } ios_mode_e;

  typedef struct packed {
    logic fast_en;
    logic slow_en;
    logic fast_stable;
    logic slow_stable;
  } ios_osc_s;

  typedef enum logic [1:0] {
    AXS_IDLE,
    AXS_WRESP,
    AXS_RDATA
  } ios_axi_e;

endpackage

// ===== src/ios_osc_sel.sv
/*
  Internal oscillator select, trim and divided clock output logic with
  an AXI4-Lite register slave. Both oscillators are modelled as enables
  on the 50 MHz system clock. Pins are synchronous to aclk.
*/
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
// How it works
// - RC divided mode: second pin drives RC clock divided by 4.
// - RC pin mode: clock from first pin, second pin is GPIO.
// - Internal divided mode: first pin GPIO, second pin gives clock over 4.
// - Internal all-pins mode: both pins GPIO, no divided clock.
// - Either internal mode makes internal oscillators the system clock.
// - Select field picks one of eight internal frequencies.
// - Fast oscillator on when field nonzero and select bit or two-speed set.
// - Slow oscillator on for field 000 with select, or timers/monitor on.
// - Timers and failure monitor tick from the slow oscillator always.
// - Trim register is 5-bit two's complement, reset to zero.
// - Trim 01111 fastest, 00000 calibrated, 10000 slowest, monotonic.
// - Trim writes change frequency within the running period; no completion flag exists.
// - Trim acts on the fast oscillator only.
// - Trim bits 7-5 ignore writes and read zero.
// - Reset loads select field 110, meaning 4 MHz.
// - Readable flag shows fast oscillator stable.
// - Readable flag shows slow oscillator stable.
// - Select bit chooses internal or configured clock.
// - Field 111 is 8 MHz, halving per code to 001, 000 is 31 kHz.
// - Select 0 runs configured mode; 1 runs selected internal clock.
module ios_osc_sel (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Oscillator pins
  input wire logic first_oscillator_pin_i,
  input wire logic second_oscillator_pin_i,
  output logic second_oscillator_pin_o,
  output logic second_oscillator_pin_oe,
  // Clock status
  output logic sys_clk_en,
  output logic slow_tick,
  output logic [4:0] fast_trim_value,
  output ios_pkg::ios_osc_s osc_state
);
  import ios_pkg::*;

  logic [2:0] fsel_q;
  logic clk_sel_q;
  logic [4:0] trim_q;
  logic [5:0] cfg_q;
  ios_axi_e axs_q;
  logic aw_got_q, w_got_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [10:0] slow_div_q;
  logic [7:0] fast_div_q;
  logic [6:0] post_q;
  logic [10:0] fast_set_q, slow_set_q;
  logic [1:0] q4_q;
  logic rc_prev_q;
  logic fast_en, slow_en, fast_tick, sel_tick, use_int, tick_src;
  logic internal_mode;

  function automatic logic [31:0] reg_read(input logic [3:0] a);
    reg_read = 32'h0000_0000;
    case (a)
      OFF_CTRL: begin
        reg_read[CTRL_FSEL_LO +: 3] = fsel_q;
        reg_read[CTRL_FAST_OK_BIT] = osc_state.fast_stable;
        reg_read[CTRL_SLOW_OK_BIT] = osc_state.slow_stable;
        reg_read[CTRL_SEL_BIT] = clk_sel_q;
      end
      OFF_TRIM: reg_read[TRIM_W-1:0] = trim_q;
      OFF_CFG: reg_read[5:0] = cfg_q;
      OFF_STAT: reg_read[3:0] = {fast_en, slow_en, use_int, sys_clk_en};
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic known(input logic [3:0] a);
    known = (a == OFF_CTRL) || (a == OFF_TRIM) || (a == OFF_CFG) || (a == OFF_STAT);
  endfunction

  // AXI write capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && !aw_got_q && !s_axi_awready && axs_q != AXS_WRESP) begin
        s_axi_awready <= 1'b1;
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_q && !s_axi_wready && axs_q != AXS_WRESP) begin
        s_axi_wready <= 1'b1;
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_got_q && w_got_q && axs_q == AXS_IDLE) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
    end
  end

  // Response sequencer, writes before reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      axs_q <= AXS_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      s_axi_arready <= 1'b0;
      case (axs_q)
        AXS_IDLE: begin
          if (aw_got_q && w_got_q) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known(aw_addr_q) ? 2'h0 : 2'h2;
            axs_q <= AXS_WRESP;
          end else if (s_axi_arvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= reg_read(s_axi_araddr);
            s_axi_rresp <= known(s_axi_araddr) ? 2'h0 : 2'h2;
            axs_q <= AXS_RDATA;
          end
        end
        AXS_WRESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            axs_q <= AXS_IDLE;
          end
        end
        AXS_RDATA: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            axs_q <= AXS_IDLE;
          end
        end
        default: axs_q <= AXS_IDLE;
      endcase
    end
  end

  logic wr_go;
  assign wr_go = aw_got_q && w_got_q && axs_q == AXS_IDLE;

  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fsel_q <= FSEL_RESET;
      clk_sel_q <= SEL_RESET;
    end else if (wr_go && aw_addr_q == OFF_CTRL && w_strb_q[0]) begin
      fsel_q <= w_data_q[CTRL_FSEL_LO +: 3];
      clk_sel_q <= w_data_q[CTRL_SEL_BIT];
    end
  end

  // Trim and configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim_q <= TRIM_RESET;
      cfg_q <= CFG_RESET;
    end else if (wr_go && w_strb_q[0]) begin
      if (aw_addr_q == OFF_TRIM)
        trim_q <= w_data_q[TRIM_W-1:0];
      if (aw_addr_q == OFF_CFG)
        cfg_q <= w_data_q[5:0];
    end
  end

  assign internal_mode = cfg_q[CFG_MODE_LO +: 2] == MODE_INT_DIV ||
                         cfg_q[CFG_MODE_LO +: 2] == MODE_INT_PINS;
  assign use_int = clk_sel_q || internal_mode;
  assign fast_en = (fsel_q != FSEL_SLOW) && (use_int || cfg_q[CFG_TSU_BIT]);
  assign slow_en = ((fsel_q == FSEL_SLOW) && (use_int || cfg_q[CFG_TSU_BIT])) ||
                   cfg_q[CFG_PWRUP_BIT] || cfg_q[CFG_WDOG_BIT] || cfg_q[CFG_FCM_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn || !slow_en)
      slow_div_q <= 11'h000;
    else if (slow_div_q == 11'(DIV_SLOW - 1))
      slow_div_q <= 11'h000;
    else
      slow_div_q <= slow_div_q + 11'h001;
  end

  // trim shifts fast period, signed, takes effect in the running period
  logic [7:0] fast_top;
  // Sign-extended trim, modulo 8 bits: negative trim lengthens the period
  assign fast_top = 8'(DIV_FAST * 4) - {{3{trim_q[4]}}, trim_q};
  always_ff @(posedge aclk) begin
    if (!aresetn || !fast_en)
      fast_div_q <= 8'h00;
    else if (fast_div_q >= fast_top)
      fast_div_q <= 8'h00;
    else
      fast_div_q <= fast_div_q + 8'h01;
  end
  assign fast_tick = fast_en && fast_div_q == 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      post_q <= 7'h00;
    else if (fast_tick)
      post_q <= post_q + 7'h01;
  end
  always_comb begin
    if (fsel_q == FSEL_SLOW)
      tick_src = slow_en && slow_div_q == 11'h000;
    else if (fsel_q == FSEL_FASTEST)
      tick_src = fast_tick;
    else
      tick_src = fast_tick && (post_q & ((7'h01 << (3'h7 - fsel_q)) - 7'h01)) == 7'h00;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !fast_en)
      fast_set_q <= 11'h000;
    else if (fast_set_q != 11'(FAST_SETTLE_CYC))
      fast_set_q <= fast_set_q + 11'h001;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !slow_en)
      slow_set_q <= 11'h000;
    else if (slow_set_q != 11'(SLOW_SETTLE_CYC))
      slow_set_q <= slow_set_q + 11'h001;
  end

  // External RC clock edge from first pin
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rc_prev_q <= 1'b0;
    else
      rc_prev_q <= first_oscillator_pin_i;
  end
  assign sel_tick = use_int ? tick_src : (first_oscillator_pin_i && !rc_prev_q);

  always_ff @(posedge aclk) begin
    if (!aresetn)
      q4_q <= 2'h0;
    else if (sel_tick)
      q4_q <= q4_q + 2'h1;
  end

  // Registered outputs and pin functions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_clk_en <= 1'b0;
      slow_tick <= 1'b0;
      fast_trim_value <= TRIM_RESET;
      osc_state <= '0;
      second_oscillator_pin_o <= 1'b0;
      second_oscillator_pin_oe <= 1'b0;
    end else begin
      sys_clk_en <= sel_tick;
      slow_tick <= slow_en && slow_div_q == 11'h000;
      fast_trim_value <= trim_q;
      osc_state.fast_en <= fast_en;
      osc_state.slow_en <= slow_en;
      osc_state.fast_stable <= fast_en && fast_set_q == 11'(FAST_SETTLE_CYC);
      osc_state.slow_stable <= slow_en && slow_set_q == 11'(SLOW_SETTLE_CYC);
      case (ios_mode_e'(cfg_q[CFG_MODE_LO +: 2]))
        // RC clock over 4 on second pin
        MODE_RC_DIV: begin
          second_oscillator_pin_oe <= 1'b1;
          second_oscillator_pin_o <= q4_q[1];
        end
        MODE_RC_PIN, MODE_INT_PINS: begin
          second_oscillator_pin_oe <= 1'b0;
          second_oscillator_pin_o <= 1'b0;
        end
        MODE_INT_DIV: begin
          second_oscillator_pin_oe <= 1'b1;
          second_oscillator_pin_o <= q4_q[1];
        end
        default: begin
          second_oscillator_pin_oe <= 1'b0;
          second_oscillator_pin_o <= 1'b0;
        end
      endcase
    end
  end

  pin_free_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_q[1:0] == MODE_INT_PINS |=> !second_oscillator_pin_oe)
    else $error("second pin driven in all-pins mode");
  fast_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (fsel_q != 3'h0 && clk_sel_q) |=> osc_state.fast_en)
    else $error("fast oscillator not enabled");
  slow_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (fsel_q == 3'h0 && clk_sel_q) |=> osc_state.slow_en && !osc_state.fast_en)
    else $error("slow oscillator enable wrong");
  trim_hi_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arready && s_axi_araddr == OFF_TRIM |-> s_axi_rdata[31:5] == 27'h0)
    else $error("trim upper bits not zero");
  fsel_rst_a: assert property (@(posedge aclk)
    !aresetn |=> fsel_q == 3'h6 && trim_q == 5'h00)
    else $error("reset values wrong");
  fast_stab_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !fast_en |=> !osc_state.fast_stable)
    else $error("fast stable while off");
  slow_stab_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !slow_en |=> !osc_state.slow_stable)
    else $error("slow stable while off");
  int_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    internal_mode |=> osc_state.fast_en == ($past(fsel_q) != 3'h0))
    else $error("internal mode not using internal clock");
  div4_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sel_tick |=> q4_q == $past(q4_q) + 2'h1)
    else $error("divide counter slipped");

endmodule

// ===== verification/ios_osc_sel_test.sv
/*
  Self-checking bench for the oscillator select block: register access,
  clock modes, frequency ladder, trim, stable flags and the slow tick.
  Assumes the block's AXI4-Lite timing and a 50 MHz bench clock.
*/
`timescale 1ns/10ps
module ios_osc_sel_test;
  import ios_pkg::*;

  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'h0;
  logic first_oscillator_pin_i = 1'h0;
  logic second_oscillator_pin_i = 1'h0;
  logic second_oscillator_pin_o;
  logic second_oscillator_pin_oe;
  logic sys_clk_en;
  logic slow_tick;
  logic [4:0] fast_trim_value;
  ios_osc_s osc_state;
  logic [1:0] last_resp;
  logic [31:0] v;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  int rc_cnt = 0;
  int p, prev, n, pc;

  ios_osc_sel u_ios_osc_sel (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .first_oscillator_pin_i,
    .second_oscillator_pin_i, .second_oscillator_pin_o,
    .second_oscillator_pin_oe, .sys_clk_en, .slow_tick,
    .fast_trim_value, .osc_state
  );

  always #10 aclk = ~aclk;

  // External RC clock: period of 10 bench cycles
  always @(posedge aclk) begin
    rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
    if (rc_cnt == 4) begin
      first_oscillator_pin_i <= ~first_oscillator_pin_i;
    end
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    // Ceiling above the roughly 41000 cycles the whole bench may take
    if (cyc == 80000) begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // Cycles between two pulses of the system clock or the slow tick
  task automatic period(input logic slow);
    do @(posedge aclk); while ((slow ? slow_tick : sys_clk_en) !== 1'h1);
    p = 0;
    do begin
      @(posedge aclk);
      p++;
    end while ((slow ? slow_tick : sys_clk_en) !== 1'h1);
  endtask

  // System clock pulses in one period of the divided output
  task automatic div_count();
    do @(posedge aclk); while (second_oscillator_pin_o !== 1'h0);
    do @(posedge aclk); while (second_oscillator_pin_o !== 1'h1);
    n = 0;
    do begin
      @(posedge aclk);
      if (sys_clk_en === 1'h1) n++;
    end while (second_oscillator_pin_o !== 1'h0);
    do begin
      @(posedge aclk);
      if (sys_clk_en === 1'h1) n++;
    end while (second_oscillator_pin_o !== 1'h1);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    check(32'(fast_trim_value), 32'h0);
    check(32'(osc_state), 32'h0);
    rd(OFF_CTRL); check(v, 32'h60);
    rd(OFF_TRIM); check(v, 32'h0);
    rd(OFF_CFG); check(v, 32'h0);
    rd(4'h2); check(32'(last_resp), 32'h2);
    $display("test reset values done");
    wr(OFF_CTRL, 32'h71);
    repeat (FAST_SETTLE_CYC + 10) @(posedge aclk);
    check(32'(osc_state), 32'hA);
    rd(OFF_CTRL); check(v, 32'h75);
    wr(OFF_CFG, 32'h2);
    rd(OFF_STAT); check(v & 32'hE, 32'hA);
    for (int f = 7; f >= 1; f--) begin
      wr(OFF_CTRL, {25'h0, f[2:0], 4'h1});
      period(1'h0);
      period(1'h0);
      if (f < 7) check(p, 2 * prev);
      prev = p;
      if (f == 7) begin
        div_count(); check(n, 4);
        check(32'(second_oscillator_pin_oe), 32'h1);
      end
    end
    $display("test frequency ladder done");
    pc = prev;
    wr(OFF_TRIM, 32'hF);
    period(1'h0);
    period(1'h0);
    check(32'(p < pc), 32'h1);
    wr(OFF_TRIM, 32'h10);
    period(1'h0);
    period(1'h0);
    check(32'(p > pc), 32'h1);
    rd(OFF_CTRL); check(v, 32'h15);
    wr(OFF_TRIM, 32'hFF);
    rd(OFF_TRIM); check(v, 32'h1F);
    check(32'(fast_trim_value), 32'h1F);
    $display("test trim done");
    wr(OFF_CTRL, 32'h01);
    repeat (SLOW_SETTLE_CYC + 10) @(posedge aclk);
    check(32'(osc_state), 32'h5);
    rd(OFF_CTRL); check(v, 32'h3);
    period(1'h1);
    period(1'h1); check(p, DIV_SLOW);
    period(1'h0);
    period(1'h0); check(p, DIV_SLOW);
    $display("test slow oscillator done");
    wr(OFF_CTRL, 32'h00);
    for (int b = 3; b <= 5; b++) begin
      wr(OFF_CFG, 32'h1 << b);
      rd(OFF_STAT); check(v & 32'hC, 32'h4);
    end
    wr(OFF_CFG, 32'h4);
    rd(OFF_STAT); check(v & 32'hC, 32'h4);
    wr(OFF_CTRL, 32'h60);
    rd(OFF_STAT); check(v & 32'hC, 32'h8);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CFG, m);
      rd(OFF_STAT); check(v & 32'h2, (m >= 2) ? 32'h2 : 32'h0);
      check(32'(second_oscillator_pin_oe), 32'(m == 0 || m == 2));
    end
    wr(OFF_CFG, 32'h0);
    period(1'h0);
    period(1'h0); check(p, 10);
    div_count(); check(n, 4);
    wr(OFF_CTRL, 32'h61);
    rd(OFF_STAT); check(v & 32'h2, 32'h2);
    $display("test clock modes done");
    results();
  end
endmodule
